// *** lvds_rx_pkg.sv ***
package lvds_rx_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // link geometry
  localparam int LANE_COUNT = 3;
  localparam int BITS_PER_LANE = 7;
  localparam int WORD_WIDTH = LANE_COUNT * BITS_PER_LANE;
  localparam int FIFO_DEPTH = 8;

  // slot counter: bits of the current frame already shifted in
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST_BEFORE = 3'h6;
  localparam logic [2:0] SLOT_FULL = 3'h7;
  localparam logic [2:0] SLOT_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int LOCK_TIME_MS = 1;
  localparam int LOCK_CYCLES = LOCK_TIME_MS * (CLK_FREQ_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and carriers
  typedef logic [WORD_WIDTH-1:0] parallel_word_t;
  localparam parallel_word_t WORD_RESET = 21'h000000;

  typedef struct packed {
    logic [LANE_COUNT-1:0] serialLanePos;
    logic [LANE_COUNT-1:0] serialLaneNeg;
  } lane_pins_t;

  typedef struct packed {
    logic valid;
    parallel_word_t data;
  } captured_word_t;

  typedef struct packed {
    logic receiverEnable;
    logic phaseLocked;
    logic linkOverrun;
    logic frameError;
  } rx_status_t;

  typedef enum logic [1:0] {OUT_IDLE, OUT_HIGH, OUT_LOW} out_state_t;

endpackage

// *** bit_sync.sv ***
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // destination reset, active low
  input wire logic [WIDTH-1:0] asyncIn, // level from another domain
  output logic [WIDTH-1:0] syncOut // synchronised level
);

  logic [WIDTH-1:0] stage1Reg;

  // stage1Reg feeds only the second flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      syncOut <= '0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end

endmodule

// *** async_fifo.sv ***
`timescale 1ns/1ps
module async_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic wrClk, // write side clock
  input wire logic wrRst_n, // write side reset, active low
  input wire logic wrValid, // write request
  output logic wrReady, // not full
  input wire logic [WIDTH-1:0] wrData, // write word
  input wire logic rdClk, // read side clock
  input wire logic rdRst_n, // read side reset, active low
  output logic rdValid, // not empty
  input wire logic rdReady, // read accept
  output logic [WIDTH-1:0] rdData // head word
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

  function automatic logic [AW:0] toGray(input logic [AW:0] bin);
    return bin ^ (bin >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrBinReg, wrGrayReg, rdBinReg, rdGrayReg;
  logic [AW:0] wrGrayInRd, rdGrayInWr;
  logic [AW:0] wrBinNext, rdBinNext;
  logic wrFire, rdFire;

  ////////////////////////////////////////////////////////////////////////////////
  // write side
  assign wrReady = (wrGrayReg != {~rdGrayInWr[AW:AW-1], rdGrayInWr[AW-2:0]});
  assign wrFire = wrValid & wrReady;
  assign wrBinNext = wrBinReg + PTR_ONE;

  always_ff @(posedge wrClk) begin
    if (wrFire) begin
      mem[wrBinReg[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk or negedge wrRst_n) begin
    if (!wrRst_n) begin
      wrBinReg <= '0;
      wrGrayReg <= '0;
    end else if (wrFire) begin
      wrBinReg <= wrBinNext;
      wrGrayReg <= toGray(wrBinNext);
    end
  end

  bit_sync #(.WIDTH(AW + 1)) rdPtrSync (
    .clk(wrClk),
    .rst_n(wrRst_n),
    .asyncIn(rdGrayReg),
    .syncOut(rdGrayInWr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read side
  assign rdValid = (rdGrayReg != wrGrayInRd);
  assign rdFire = rdValid & rdReady;
  assign rdBinNext = rdBinReg + PTR_ONE;
  assign rdData = mem[rdBinReg[AW-1:0]];

  always_ff @(posedge rdClk or negedge rdRst_n) begin
    if (!rdRst_n) begin
      rdBinReg <= '0;
      rdGrayReg <= '0;
    end else if (rdFire) begin
      rdBinReg <= rdBinNext;
      rdGrayReg <= toGray(rdBinNext);
    end
  end

  bit_sync #(.WIDTH(AW + 1)) wrPtrSync (
    .clk(rdClk),
    .rst_n(rdRst_n),
    .asyncIn(wrGrayReg),
    .syncOut(wrGrayInRd)
  );

endmodule

// *** lvds_display_link_deserializer.sv ***
`timescale 1ns/1ps
// Function
// - three 7-bit shift registers give 21 bits
// - lanes sampled at seven times link clock
// - one 21-bit word per link clock cycle
// - output word valid at parallel clock fall
// - word passes through unaltered, same order
// - shutdown stops clocking, disables line receivers; here clocks keep running and flops are held in clear
// - shutdown low clears every register to zero; the word buffer memory here is not cleared
// - data trusted only after 1 ms lock
// - off state reached within 400 ns
// - parallel clock runs near fifty percent duty
module lvds_display_link_deserializer #(
  parameter int LOCK_CYCLES = lvds_rx_pkg::LOCK_CYCLES,
  parameter int DEPTH = lvds_rx_pkg::FIFO_DEPTH
) (
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic bitClk, // bit clock, seven times link clock
  input wire logic linkClockIn, // forwarded link clock, pin level
  input wire lvds_rx_pkg::lane_pins_t lanePins, // differential serial lanes
  input wire logic shutdownClear_n, // shutdown and clear, active low
  output lvds_rx_pkg::parallel_word_t parallelWordOut, // recovered word
  output logic parallelClockOut, // regenerated word clock
  output lvds_rx_pkg::rx_status_t status // receiver status flags
);

  import lvds_rx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // a lane reads high only when the pair is driven positive
  function automatic logic [LANE_COUNT-1:0] laneLevel(
    input logic [LANE_COUNT-1:0] pos,
    input logic [LANE_COUNT-1:0] neg
  );
    return pos & ~neg;
  endfunction

  // first bit of a frame ends in the top position of its lane
  function automatic logic [BITS_PER_LANE-1:0] shiftIn(
    input logic [BITS_PER_LANE-1:0] old,
    input logic serialBit
  );
    return {old[BITS_PER_LANE-2:0], serialBit};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // resets: shutdown clears asynchronously, release is synchronised per domain

  logic clearAll_n;
  logic bitRstStage1Reg, bitRst_n;
  logic sysRstStage1Reg, sysRst_n;

  assign clearAll_n = rst_n & shutdownClear_n;

  // clocks keep running in shutdown; holding every flop but the word buffer memory in clear keeps the
  // logic idle without a gated clock, at the cost of some clock power

  // the clear takes effect without any clock, so the off state is immediate
  always_ff @(posedge bitClk or negedge clearAll_n) begin
    if (!clearAll_n) begin
      bitRstStage1Reg <= 1'b0;
      bitRst_n <= 1'b0;
    end else begin
      bitRstStage1Reg <= 1'b1;
      bitRst_n <= bitRstStage1Reg;
    end
  end

  always_ff @(posedge clk or negedge clearAll_n) begin
    if (!clearAll_n) begin
      sysRstStage1Reg <= 1'b0;
      sysRst_n <= 1'b0;
    end else begin
      sysRstStage1Reg <= 1'b1;
      sysRst_n <= sysRstStage1Reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: pin capture

  logic linkClkSync;
  logic [LANE_COUNT-1:0] lanePosSync, laneNegSync;
  logic [LANE_COUNT-1:0] laneBits;
  logic linkClkPrevReg;
  logic linkRise;

  // clock pin and data pins share one synchroniser so their latency matches
  bit_sync #(.WIDTH(1 + 2 * LANE_COUNT)) pinSync (
    .clk(bitClk),
    .rst_n(bitRst_n),
    .asyncIn({linkClockIn, lanePins.serialLanePos, lanePins.serialLaneNeg}),
    .syncOut({linkClkSync, lanePosSync, laneNegSync})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: warm-up and edge arming

  logic [1:0] pinWarmReg;
  logic pinsValid;
  logic linkArmedReg;

  // the synchroniser shows its reset zero for two edges after release
  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      pinWarmReg <= 2'h0;
    end else begin
      pinWarmReg <= {pinWarmReg[0], 1'b1};
    end
  end

  assign pinsValid = pinWarmReg[1];

  // a release in mid-frame may find the clock pin high; only a rise that
  // follows a real low sample may start framing, or alignment is off
  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      linkArmedReg <= 1'b0;
    end else if (pinsValid && !linkClkSync) begin
      linkArmedReg <= 1'b1;
    end
  end

  // line receivers are off while held in clear or still warming up
  assign laneBits = pinsValid ? laneLevel(lanePosSync, laneNegSync) :
                    {LANE_COUNT{1'b0}};

  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      linkClkPrevReg <= 1'b0;
    end else begin
      linkClkPrevReg <= linkClkSync;
    end
  end

  // an unarmed detector would take a high pin after release for a rise
  assign linkRise = linkArmedReg & linkClkSync & ~linkClkPrevReg;

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: slot counting and alignment

  logic [2:0] slotCountReg;
  logic alignedReg;
  logic frameErrorReg;
  logic wordComplete;

  // slot 0 is the bit sampled together with the link clock rise
  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      slotCountReg <= SLOT_RESET;
    end else if (linkRise) begin
      slotCountReg <= SLOT_FIRST;
    end else if (slotCountReg != SLOT_FULL) begin
      slotCountReg <= slotCountReg + SLOT_FIRST;
    end
  end

  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      alignedReg <= 1'b0;
    end else if (linkRise) begin
      alignedReg <= 1'b1;
    end
  end

  // a rise that comes fewer than seven bits after the last one breaks framing
  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      frameErrorReg <= 1'b0;
    end else if (linkRise && alignedReg && slotCountReg != SLOT_FULL) begin
      frameErrorReg <= 1'b1;
    end
  end

  assign wordComplete = alignedReg && !linkRise && (slotCountReg == SLOT_LAST_BEFORE);

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: shift registers and word capture

  logic [BITS_PER_LANE-1:0] laneShiftReg [LANE_COUNT];
  parallel_word_t wordAssembled;
  captured_word_t captureReg;
  logic fifoWrReady;
  logic overrunReg;

  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      for (int k = 0; k < LANE_COUNT; k++) begin
        laneShiftReg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < LANE_COUNT; k++) begin
        laneShiftReg[k] <= shiftIn(laneShiftReg[k], laneBits[k]);
      end
    end
  end

  // lane k fills bits 7k+6 down to 7k, with no recoding
  always_comb begin
    wordAssembled = WORD_RESET;
    for (int k = 0; k < LANE_COUNT; k++) begin
      wordAssembled[k*BITS_PER_LANE +: BITS_PER_LANE] =
        shiftIn(laneShiftReg[k], laneBits[k]);
    end
  end

  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      captureReg <= '0;
    end else begin
      captureReg.valid <= wordComplete;
      if (wordComplete) begin
        captureReg.data <= wordAssembled;
      end
    end
  end

  // the serial link cannot be paused, so a full buffer drops the word
  always_ff @(posedge bitClk or negedge bitRst_n) begin
    if (!bitRst_n) begin
      overrunReg <= 1'b0;
    end else if (captureReg.valid && !fifoWrReady) begin
      overrunReg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // crossing: word buffer between the link and system clocks

  logic fifoRdValid;
  logic fifoRdReady;
  parallel_word_t fifoRdData;

  async_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(DEPTH)) wordFifo (
    .wrClk(bitClk),
    .wrRst_n(bitRst_n),
    .wrValid(captureReg.valid),
    .wrReady(fifoWrReady),
    .wrData(captureReg.data),
    .rdClk(clk),
    .rdRst_n(sysRst_n),
    .rdValid(fifoRdValid),
    .rdReady(fifoRdReady),
    .rdData(fifoRdData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // system domain: parallel output sequencer

  out_state_t outStateReg, outStateNext;
  logic popWord;

  // the buffer is drained at most every second cycle; it stalls in high phase
  assign fifoRdReady = (outStateReg != OUT_HIGH);
  assign popWord = fifoRdValid & fifoRdReady;

  always_comb begin
    outStateNext = outStateReg;
    case (outStateReg)
      OUT_IDLE: begin
        if (popWord) begin
          outStateNext = OUT_HIGH;
        end
      end
      OUT_HIGH: begin
        outStateNext = OUT_LOW;
      end
      OUT_LOW: begin
        outStateNext = popWord ? OUT_HIGH : OUT_IDLE;
      end
      default: begin
        outStateNext = OUT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      outStateReg <= OUT_IDLE;
    end else begin
      outStateReg <= outStateNext;
    end
  end

  // data changes with the rising clock so it is a full half period old at fall
  always_ff @(posedge clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      parallelWordOut <= WORD_RESET;
    end else if (popWord) begin
      parallelWordOut <= fifoRdData;
    end
  end

  // one cycle high, one cycle low per word; stops when no word waits
  always_ff @(posedge clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      parallelClockOut <= 1'b0;
    end else begin
      parallelClockOut <= (outStateNext == OUT_HIGH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // system domain: lock delay and status

  logic [31:0] lockCountReg;
  logic lockedReg;
  logic overrunSync, frameErrorSync;
  localparam logic [31:0] LOCK_LAST = 32'(LOCK_CYCLES - 1);
  localparam logic [31:0] COUNT_ONE = 32'h00000001;

  // output is not trusted until the lock interval has run from release
  always_ff @(posedge clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      lockCountReg <= 32'h00000000;
      lockedReg <= 1'b0;
    end else if (!lockedReg) begin
      lockCountReg <= lockCountReg + COUNT_ONE;
      lockedReg <= (lockCountReg == LOCK_LAST);
    end
  end

  bit_sync #(.WIDTH(2)) flagSync (
    .clk(clk),
    .rst_n(sysRst_n),
    .asyncIn({overrunReg, frameErrorReg}),
    .syncOut({overrunSync, frameErrorSync})
  );

  always_ff @(posedge clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      status <= '0;
    end else begin
      status.receiverEnable <= 1'b1;
      status.phaseLocked <= lockedReg;
      status.linkOverrun <= overrunSync;
      status.frameError <= frameErrorSync;
    end
  end

endmodule

// *** lvds_rx_properties.sv ***
`timescale 1ns/1ps
module lvds_rx_properties #(
  parameter int LOCK_CYCLES = 20,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic bitClk, // bit clock, seven times link clock
  input wire logic linkClockIn, // framing pin
  input wire lvds_rx_pkg::lane_pins_t lanePins, // serial lanes
  input wire logic shutdownClear_n, // shutdown, active low
  input wire lvds_rx_pkg::parallel_word_t parallelWordOut, // word out
  input wire logic parallelClockOut, // word clock
  input wire lvds_rx_pkg::rx_status_t status // flags
);
  import lvds_rx_pkg::*;
  logic runOk;
  int enCount;
  assign runOk = rst_n && shutdownClear_n;
  // cycles spent enabled, saturating so a long run cannot wrap
  always_ff @(posedge clk or negedge runOk) begin
    if (!runOk) begin
      enCount <= 0;
    end else if (status.receiverEnable && enCount < LOCK_CYCLES + 8) begin
      enCount <= enCount + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!runOk);
  ////////////////////////////////////////////////////////////////////////////////
  a_clock_pulse_one: assert property ($rose(parallelClockOut) |=> !parallelClockOut)
    else $error("word clock high longer than one cycle");
  a_word_only_rise: assert property (!$rose(parallelClockOut) |-> $stable(parallelWordOut))
    else $error("word changed without a word clock rise");
  a_data_at_fall: assert property ($rose(parallelClockOut) |=> $stable(parallelWordOut))
    else $error("word not stable at word clock fall");
  // no disable here: the clear itself is what is watched
  a_shutdown_clears: assert property (disable iff (1'b0) !runOk |->
    parallelWordOut == WORD_RESET && !parallelClockOut && status == '0)
    else $error("outputs not cleared in shutdown");
  a_enable_after_release: assert property ($rose(runOk) |-> ##[2:4] status.receiverEnable)
    else $error("receiver not enabled after release");
  a_lock_not_early: assert property (status.phaseLocked |-> enCount >= LOCK_CYCLES - 1)
    else $error("lock reported too early");
  a_lock_not_late: assert property (enCount >= LOCK_CYCLES + 2 |-> status.phaseLocked)
    else $error("lock reported too late");
  a_lock_needs_enable: assert property (status.phaseLocked |-> status.receiverEnable)
    else $error("lock without receiver enabled");
  a_idle_clock_low: assert property (!status.receiverEnable |-> !parallelClockOut)
    else $error("word clock runs while disabled");
  c_word_out: cover property ($rose(parallelClockOut));
  c_locked: cover property ($rose(status.phaseLocked));
  c_frame_err: cover property ($rose(status.frameError));
endmodule
bind lvds_display_link_deserializer lvds_rx_properties #(.LOCK_CYCLES(LOCK_CYCLES),
  .DEPTH(DEPTH)) uProps (.clk(clk), .rst_n(rst_n), .bitClk(bitClk),
  .linkClockIn(linkClockIn), .lanePins(lanePins), .shutdownClear_n(shutdownClear_n),
  .parallelWordOut(parallelWordOut), .parallelClockOut(parallelClockOut), .status(status));

// *** link_tx_model.sv ***
`timescale 1ns/1ps
module link_tx_model (
  input wire logic bitClk, // bit clock
  input wire logic go, // start a burst
  input wire lvds_rx_pkg::parallel_word_t base, // seed of the burst
  input wire logic [7:0] frames, // frames in the burst
  input wire logic shortFrame, // second frame one bit short
  output logic linkClockIn, // forwarded link clock
  output lvds_rx_pkg::lane_pins_t lanePins, // serial lanes
  output logic busy // burst running
);
  import lvds_rx_pkg::*;
  logic [2:0] slot = 3'h0;
  logic [7:0] idx = 8'h00;
  logic [2:0] bits;
  parallel_word_t cur;
  initial begin
    busy = 1'b0;
    linkClockIn = 1'b0;
    lanePins = '0;
  end
  // link rate is scaled to the bench bit clock, far below the real lock range
  always @(posedge bitClk) begin
    if (!busy && go) begin
      busy = 1'b1;
      slot = 3'h0;
      idx = 8'h00;
    end else if (busy) begin
      slot = slot + 3'h1;
      if (slot == ((shortFrame && idx == 8'h01) ? 3'h6 : 3'h7)) begin
        slot = 3'h0;
        idx = idx + 8'h01;
      end
      if (idx == frames) busy = 1'b0;
    end
    cur = base + parallel_word_t'(idx) * 21'h0a4925;
    // idle lanes flip every bit so a stale level is never mistaken for data
    for (int k = 0; k < LANE_COUNT; k++) begin
      bits[k] = busy ? cur[7 * k + 6 - slot] : ~lanePins.serialLanePos[k];
    end
    linkClockIn <= busy && slot < 3'h4;
    lanePins <= {bits, ~bits};
  end
endmodule

// *** test_lvds_display_link_deserializer.sv ***
`timescale 1ns/1ps
module test_lvds_display_link_deserializer;
  import lvds_rx_pkg::*;
  localparam int LOCK = 20;
  logic clk = 1'b0;
  logic bitClk = 1'b0;
  logic rst_n = 1'b1;
  logic shutdownClear_n = 1'b1;
  logic go = 1'b0;
  logic shortFrame = 1'b0;
  logic [7:0] frames = 8'h00;
  parallel_word_t base = 21'h000000;
  logic linkClockIn;
  logic busy;
  logic parallelClockOut;
  logic pcoPrev = 1'b0;
  lane_pins_t lanePins;
  parallel_word_t parallelWordOut;
  rx_status_t status;
  parallel_word_t rxq[$];
  int failCount = 0;
  int testsRun = 0;
  int cycles = 0;
  lvds_display_link_deserializer #(.LOCK_CYCLES(LOCK), .DEPTH(FIFO_DEPTH)) u_dut (
    .clk(clk), .rst_n(rst_n), .bitClk(bitClk), .linkClockIn(linkClockIn),
    .lanePins(lanePins), .shutdownClear_n(shutdownClear_n),
    .parallelWordOut(parallelWordOut), .parallelClockOut(parallelClockOut), .status(status));
  link_tx_model uTx (.bitClk(bitClk), .go(go), .base(base), .frames(frames),
    .shortFrame(shortFrame), .linkClockIn(linkClockIn), .lanePins(lanePins), .busy(busy));
  initial forever #50 clk = ~clk;
  initial begin
    #7;
    forever #16 bitClk = ~bitClk;
  end
  // words are taken at the fall of the word clock, as a display would
  always @(negedge clk) begin
    if (pcoPrev && !parallelClockOut) rxq.push_back(parallelWordOut);
    pcoPrev = parallelClockOut;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failCount++;
      testDone();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmpWord(string what, parallel_word_t exp, parallel_word_t got);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpBit(string what, logic exp, logic got);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 300 && busy !== 1'b0; i++) tick(1);
    cmpBit("burst ended", 1'b0, busy);
    tick(12);
  endtask
  task automatic sendFrames(parallel_word_t b, logic [7:0] n, logic s);
    base = b;
    frames = n;
    shortFrame = s;
    go = 1'b1;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
    cmpBit("burst started", 1'b1, busy);
    go = 1'b0;
    waitIdle();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    cmpWord("word in reset", WORD_RESET, parallelWordOut);
    cmpBit("clock in reset", 1'b0, parallelClockOut);
    cmpWord("status in reset", 21'h000000, parallel_word_t'(status));
    rst_n = 1'b1;
    tick(4);
    cmpBit("receiver enable", 1'b1, status.receiverEnable);
    cmpBit("early lock", 1'b0, status.phaseLocked);
    tick(LOCK + 4);
    cmpBit("lock", 1'b1, status.phaseLocked);
    $display("test reset done");
  endtask
  task automatic testStream(parallel_word_t b);
    rxq.delete();
    sendFrames(b, 8'h0c, 1'b0);
    cmpWord("word count", 21'h00000c, parallel_word_t'(rxq.size()));
    cmpBit("no overrun", 1'b0, status.linkOverrun);
    foreach (rxq[i]) begin
      cmpWord("word", b + parallel_word_t'(i) * 21'h0a4925, rxq[i]);
    end
    $display("test stream done");
  endtask
  task automatic testFrameError();
    cmpBit("no frame error", 1'b0, status.frameError);
    sendFrames(21'h0f0f0f, 8'h04, 1'b1);
    cmpBit("frame error", 1'b1, status.frameError);
    $display("test frame error done");
  endtask
  task automatic testShutdown();
    base = 21'h1c71c7;
    frames = 8'h14;
    go = 1'b1;
    tick(10);
    go = 1'b0;
    shutdownClear_n = 1'b0;
    tick(4);
    cmpWord("word off", WORD_RESET, parallelWordOut);
    cmpBit("clock off", 1'b0, parallelClockOut);
    cmpWord("status off", 21'h000000, parallel_word_t'(status));
    shutdownClear_n = 1'b1;
    waitIdle();
    tick(LOCK + 8);
    cmpBit("flag cleared", 1'b0, status.frameError);
    cmpBit("relock", 1'b1, status.phaseLocked);
    $display("test shutdown done");
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    // a real falling edge on reset, so no clear depends on time-zero ordering
    #2;
    rst_n = 1'b0;
    tick(12);
    testReset();
    testStream(21'h15a3c6);
    testFrameError();
    testShutdown();
    testStream(21'h0b5e21);
    testDone();
  end
endmodule
